// *** fmv_flash_cmd_seq.sv ***
// command sequencer for margin level, data flash erase verify and program commands
`timescale 1ns/1ps
module fmv_flash_cmd_seq #(
  parameter logic [6:0]  PF_BLOCK = fmv_pkg::BLK_PFLASH,
  parameter logic [6:0]  DF_BLOCK = fmv_pkg::BLK_DFLASH,
  parameter logic [16:0] DF_SIZE  = fmv_pkg::DF_BYTES
) (
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [15:0] regRdata,
  // chip mode and protection
  input  wire logic        specialMode,
  input  wire logic        dflashProtected,
  // data flash array port
  output logic             memReq,
  output logic             memWrite,
  output logic      [15:0] memAddr,
  output logic      [15:0] memWdata,
  input  wire logic        memAck,
  input  wire logic [15:0] memRdata,
  input  wire logic        memEccErr,
  input  wire logic        memEccUncorr,
  // margin levels seen by the read path
  output logic      [2:0]  pflashMargin,
  output logic      [2:0]  dflashMargin,
  // command interrupt request
  output logic             cmdIrq
);

  fmv_pkg::fmv_state_t state_q;
  fmv_pkg::fmv_state_t state_d;

  logic [15:0] cmdParam_q [0:5];
  logic [2:0]  paramIdx_q;
  logic [7:0]  config_q;
  logic        cmd_complete_flag_q;
  logic        access_error_flag_q;
  logic        protErr_q;
  logic        verErr_q;
  logic        uncErr_q;
  logic [2:0]  pMargin_q;
  logic [2:0]  dMargin_q;
  logic [15:0] addr_q;
  logic [15:0] count_q;
  logic [2:0]  pgIdx_q;
  logic [15:0] memWdata_q;
  logic [15:0] rdata_q;

  logic        wrStatus;
  logic        launch;
  logic [7:0]  cmdCode;
  logic [6:0]  blkSel;
  logic [15:0] mrgSet;
  logic        isMargin;
  logic        access_error_flag;
  logic        setAcc;
  logic        setProt;
  logic        setVer;
  logic        setUnc;
  logic        applyMargin;
  logic        lastWord;
  logic [16:0] rangeEnd;
  logic [7:0]  statusByte;

  function automatic logic marginBlockOk(input logic [6:0] blk);
    marginBlockOk = (blk == PF_BLOCK) || (blk == DF_BLOCK);
  endfunction : marginBlockOk

  // start plus byte length of n words must stay inside the data flash
  function automatic logic dfRangeOk(input logic [15:0] start, input logic [16:0] bytes);
    logic [17:0] stop;
    stop      = {2'b00, start} + {1'b0, bytes};
    dfRangeOk = (stop <= {1'b0, DF_SIZE});
  endfunction : dfRangeOk

  // global address must land inside the data flash block
  function automatic logic dfGlobalOk(input logic [6:0] blk, input logic [15:0] start);
    dfGlobalOk = (blk == DF_BLOCK) && ({1'b0, start} < DF_SIZE);
  endfunction : dfGlobalOk

  assign wrStatus = regWrStb && (regAddr == fmv_pkg::REG_STATUS);
  // launch only while idle; writing the complete bit while busy is ignored
  assign launch   = wrStatus && regWdata[fmv_pkg::ST_COMPLETE] && cmd_complete_flag_q;

  assign cmdCode  = cmdParam_q[0][15:8];
  assign blkSel   = cmdParam_q[0][6:0];
  assign mrgSet   = cmdParam_q[fmv_pkg::IDX_ADDR];
  assign isMargin = (cmdCode == fmv_pkg::CMD_USER_MRG) || (cmdCode == fmv_pkg::CMD_FLD_MRG);
  assign rangeEnd = {cmdParam_q[fmv_pkg::IDX_COUNT], 1'b0};

  // parameter validation, evaluated in the check state only
  always_comb begin
    access_error_flag = 1'b0;
    case (cmdCode)
      fmv_pkg::CMD_USER_MRG: begin
        if (paramIdx_q != fmv_pkg::IDX_ADDR)
          access_error_flag = 1'b1;
        if (!marginBlockOk(blkSel))
          access_error_flag = 1'b1;
        if (mrgSet > fmv_pkg::MRG_USER_MAX)
          access_error_flag = 1'b1;
      end
      fmv_pkg::CMD_FLD_MRG: begin
        if (!specialMode)
          access_error_flag = 1'b1;
        if (paramIdx_q != fmv_pkg::IDX_ADDR)
          access_error_flag = 1'b1;
        if (!marginBlockOk(blkSel))
          access_error_flag = 1'b1;
        if (mrgSet > fmv_pkg::MRG_FLD_MAX)
          access_error_flag = 1'b1;
      end
      fmv_pkg::CMD_EV_SECT: begin
        if (paramIdx_q != fmv_pkg::IDX_COUNT)
          access_error_flag = 1'b1;
        if (!dfGlobalOk(blkSel, mrgSet))
          access_error_flag = 1'b1;
        if (mrgSet[0])
          access_error_flag = 1'b1;
        if (!dfRangeOk(mrgSet, rangeEnd))
          access_error_flag = 1'b1;
      end
      fmv_pkg::CMD_PROG_DF: begin
        if ((paramIdx_q < fmv_pkg::IDX_PROG_MIN) || (paramIdx_q > fmv_pkg::IDX_PROG_MAX))
          access_error_flag = 1'b1;
        if (!dfGlobalOk(blkSel, mrgSet))
          access_error_flag = 1'b1;
        if (mrgSet[0])
          access_error_flag = 1'b1;
        // words = index - 1, so the byte span is twice that
        if (!dfRangeOk(mrgSet, {13'h0000, paramIdx_q - 3'h1, 1'b0}))
          access_error_flag = 1'b1;
      end
      default: access_error_flag = 1'b1;
    endcase
  end

  assign setAcc      = (state_q == fmv_pkg::SQ_CHECK) && access_error_flag;
  assign setProt     = (state_q == fmv_pkg::SQ_CHECK) && !access_error_flag &&
                       (cmdCode == fmv_pkg::CMD_PROG_DF) && dflashProtected;
  // margin state only moves on a fully validated command
  assign applyMargin = (state_q == fmv_pkg::SQ_CHECK) && !access_error_flag && isMargin;
  assign lastWord    = (pgIdx_q == paramIdx_q);

  // read checks: erased pattern for verify, written value for program
  always_comb begin
    setVer = 1'b0;
    setUnc = 1'b0;
    if (memAck && (state_q == fmv_pkg::SQ_EV_RD)) begin
      setVer = memEccErr || memEccUncorr || (memRdata != fmv_pkg::ERASED_WORD);
      setUnc = memEccUncorr;
    end else if (memAck && (state_q == fmv_pkg::SQ_PG_RD)) begin
      setVer = memEccErr || memEccUncorr || (memRdata != memWdata_q);
      setUnc = memEccUncorr;
    end
  end

  // margin and rejected commands finish after a single check cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      fmv_pkg::SQ_IDLE: begin
        if (launch)
          state_d = fmv_pkg::SQ_CHECK;
      end
      fmv_pkg::SQ_CHECK: begin
        if (access_error_flag || setProt || isMargin)
          state_d = fmv_pkg::SQ_DONE;
        else if (cmdCode == fmv_pkg::CMD_EV_SECT)
          state_d = (cmdParam_q[fmv_pkg::IDX_COUNT] == 16'h0000) ? fmv_pkg::SQ_DONE : fmv_pkg::SQ_EV_RD;
        else
          state_d = fmv_pkg::SQ_PG_WR;
      end
      fmv_pkg::SQ_EV_RD: begin
        if (memAck && (count_q == 16'h0001))
          state_d = fmv_pkg::SQ_DONE;
      end
      fmv_pkg::SQ_PG_WR: begin
        if (memAck)
          state_d = fmv_pkg::SQ_PG_RD;
      end
      fmv_pkg::SQ_PG_RD: begin
        if (memAck)
          state_d = lastWord ? fmv_pkg::SQ_DONE : fmv_pkg::SQ_PG_WR;
      end
      fmv_pkg::SQ_DONE: state_d = fmv_pkg::SQ_IDLE;
      default:          state_d = fmv_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      state_q <= fmv_pkg::SQ_IDLE;
    else if (clkEn)
      state_q <= state_d;
  end

  // parameter array and index; frozen while a command runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      paramIdx_q <= fmv_pkg::INDEX_RST;
    else if (clkEn && cmd_complete_flag_q && regWrStb && (regAddr == fmv_pkg::REG_INDEX))
      paramIdx_q <= regWdata[2:0];
  end

  // words past the last legal index are dropped, not wrapped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++)
        cmdParam_q[i] <= 16'h0000;
    end else if (clkEn && cmd_complete_flag_q && regWrStb && (regAddr == fmv_pkg::REG_PARAM) &&
                 (paramIdx_q <= fmv_pkg::IDX_PROG_MAX))
      cmdParam_q[paramIdx_q] <= regWdata;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      config_q <= fmv_pkg::CONFIG_RST;
    else if (clkEn && regWrStb && (regAddr == fmv_pkg::REG_CONFIG))
      config_q <= {regWdata[fmv_pkg::CFG_IRQ_EN], 7'h00};
  end

  // status flags: hardware set beats a same-cycle software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      cmd_complete_flag_q <= 1'b1;
    else if (clkEn) begin
      if (state_q == fmv_pkg::SQ_DONE)
        cmd_complete_flag_q <= 1'b1;
      else if (launch)
        cmd_complete_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      access_error_flag_q <= 1'b0;
    else if (clkEn) begin
      if (setAcc)
        access_error_flag_q <= 1'b1;
      else if (wrStatus && regWdata[fmv_pkg::ST_ACCESS])
        access_error_flag_q <= 1'b0;
    end
  end

  // erase verify never reaches setProt, so protection stays clear for it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      protErr_q <= 1'b0;
    else if (clkEn) begin
      if (setProt)
        protErr_q <= 1'b1;
      else if (wrStatus && regWdata[fmv_pkg::ST_PROTECT])
        protErr_q <= 1'b0;
    end
  end

  // verify flags describe the last command only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      verErr_q <= 1'b0;
    else if (clkEn) begin
      if (setVer)
        verErr_q <= 1'b1;
      else if (launch)
        verErr_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      uncErr_q <= 1'b0;
    else if (clkEn) begin
      if (setUnc)
        uncErr_q <= 1'b1;
      else if (launch)
        uncErr_q <= 1'b0;
    end
  end

  // margins survive rejected commands untouched
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      pMargin_q <= fmv_pkg::MARGIN_RST;
    else if (clkEn && applyMargin && (blkSel == PF_BLOCK))
      pMargin_q <= mrgSet[2:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      dMargin_q <= fmv_pkg::MARGIN_RST;
    else if (clkEn && applyMargin && (blkSel != PF_BLOCK))
      dMargin_q <= mrgSet[2:0];
  end

  // address walker, word counter and program data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      addr_q <= 16'h0000;
    else if (clkEn) begin
      if (state_q == fmv_pkg::SQ_CHECK)
        addr_q <= mrgSet;
      else if (memAck && ((state_q == fmv_pkg::SQ_EV_RD) || ((state_q == fmv_pkg::SQ_PG_RD) && !lastWord)))
        addr_q <= 16'(addr_q + fmv_pkg::WORD_STEP);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      count_q <= 16'h0000;
    else if (clkEn) begin
      if (state_q == fmv_pkg::SQ_CHECK)
        count_q <= cmdParam_q[fmv_pkg::IDX_COUNT];
      else if (memAck && (state_q == fmv_pkg::SQ_EV_RD))
        count_q <= 16'(count_q - 16'h0001);
    end
  end

  // next program word is loaded when the read-back of the previous one is acknowledged
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pgIdx_q    <= 3'h0;
      memWdata_q <= 16'h0000;
    end else if (clkEn) begin
      if (state_q == fmv_pkg::SQ_CHECK) begin
        pgIdx_q    <= fmv_pkg::IDX_PROG_MIN;
        memWdata_q <= cmdParam_q[fmv_pkg::IDX_PROG_MIN];
      end else if (memAck && (state_q == fmv_pkg::SQ_PG_RD) && !lastWord) begin
        pgIdx_q    <= 3'(pgIdx_q + 3'h1);
        memWdata_q <= cmdParam_q[3'(pgIdx_q + 3'h1)];
      end
    end
  end

  // request holds until the array acknowledges
  assign memReq   = (state_q == fmv_pkg::SQ_EV_RD) || (state_q == fmv_pkg::SQ_PG_WR) ||
                    (state_q == fmv_pkg::SQ_PG_RD);
  assign memWrite = (state_q == fmv_pkg::SQ_PG_WR);
  assign memAddr  = addr_q;
  assign memWdata = memWdata_q;

  assign statusByte = {cmd_complete_flag_q, 1'b0, access_error_flag_q, protErr_q, 2'b00, verErr_q, uncErr_q};

  // read data lives one cycle so an idle bus reads as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rdata_q <= 16'h0000;
    else if (clkEn && regRdStb) begin
      case (regAddr)
        fmv_pkg::REG_CONFIG: rdata_q <= {8'h00, config_q};
        fmv_pkg::REG_STATUS: rdata_q <= {8'h00, statusByte};
        fmv_pkg::REG_INDEX:  rdata_q <= {13'h0000, paramIdx_q};
        fmv_pkg::REG_PARAM:  rdata_q <= (paramIdx_q <= fmv_pkg::IDX_PROG_MAX) ? cmdParam_q[paramIdx_q] : 16'h0000;
        fmv_pkg::REG_MARGIN: rdata_q <= {9'h000, dMargin_q, 1'b0, pMargin_q};
        default:             rdata_q <= 16'h0000;
      endcase
    end else if (clkEn)
      rdata_q <= 16'h0000;
  end

  assign regRdata     = rdata_q;
  assign pflashMargin = pMargin_q;
  assign dflashMargin = dMargin_q;
  assign cmdIrq       = cmd_complete_flag_q && config_q[fmv_pkg::CFG_IRQ_EN];

endmodule : fmv_flash_cmd_seq

// *** fmv_flash_cmd_seq_sva.sv ***
// port-level assertions for the flash command sequencer
`timescale 1ns/1ps
module fmv_flash_cmd_seq_sva #(
  parameter logic [16:0] DF_SIZE = fmv_pkg::DF_BYTES
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  // register port
  input wire logic        regWrStb,
  input wire logic        regRdStb,
  input wire logic [15:0] regRdata,
  // array side
  input wire logic        dflashProtected,
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [15:0] memAddr,
  input wire logic        memAck,
  input wire logic [2:0]  pflashMargin,
  input wire logic [2:0]  dflashMargin,
  input wire logic        cmdIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence sWaitAck;
    memReq && !memAck;
  endsequence
  sequence sStillHeld;
    memReq && $stable(memAddr) && $stable(memWrite);
  endsequence

  chk_req_held_ack: assert property (sWaitAck |=> sStillHeld)
    else $error("array request dropped before ack");
  chk_rd_data_idle: assert property ($past(clkEn) && !$past(regRdStb) |-> regRdata == 16'h0000)
    else $error("read data not zero outside read cycle");
  chk_write_has_req: assert property (memWrite |-> memReq)
    else $error("write without request");
  chk_addr_word_even: assert property (memReq |-> !memAddr[0])
    else $error("odd array address");
  chk_addr_in_block: assert property (memReq |-> {1'b0, memAddr} < DF_SIZE)
    else $error("array address past block end");
  chk_prot_no_write: assert property (memWrite |-> !dflashProtected)
    else $error("write into protected area");
  chk_margin_legal: assert property (pflashMargin <= 3'h4 && dflashMargin <= 3'h4)
    else $error("margin level out of range");
  chk_margin_after_launch: assert property ($changed({pflashMargin, dflashMargin})
    |-> $past(regWrStb, 2) || $past(regWrStb, 3) || $past(regWrStb, 4))
    else $error("margin changed without launch");
  chk_irq_busy_low: assert property (memReq |-> !cmdIrq)
    else $error("interrupt while command busy");
endmodule : fmv_flash_cmd_seq_sva

bind fmv_flash_cmd_seq fmv_flash_cmd_seq_sva #(.DF_SIZE(DF_SIZE)) uChk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdata(regRdata), .dflashProtected(dflashProtected), .memReq(memReq), .memWrite(memWrite),
  .memAddr(memAddr), .memAck(memAck), .pflashMargin(pflashMargin), .dflashMargin(dflashMargin),
  .cmdIrq(cmdIrq));

// *** fmv_flash_cmd_seq_tb.sv ***
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module fmv_flash_cmd_seq_tb;
  localparam logic [3:0] ST = fmv_pkg::REG_STATUS;
  localparam logic [3:0] MG = fmv_pkg::REG_MARGIN;
  localparam logic [7:0] UM = fmv_pkg::CMD_USER_MRG;
  localparam logic [7:0] FM = fmv_pkg::CMD_FLD_MRG;
  localparam logic [15:0] EV = {fmv_pkg::CMD_EV_SECT, 8'h10};
  localparam logic [15:0] PG = {fmv_pkg::CMD_PROG_DF, 8'h10};
  logic        sysClk = 1'b0, rstN = 1'b0, clkEn = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
  logic        specialMode = 1'b0, dflashProtected = 1'b0, memAck = 1'b0, memEccErr = 1'b0;
  logic        memEccUncorr = 1'b0, injUnc = 1'b0, memReq, memWrite, cmdIrq;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000, memRdata = 16'h0000, regRdata, memAddr, memWdata;
  logic [2:0]  pflashMargin, dflashMargin;
  logic [15:0] flashMem [0:15];
  int          nFail = 0, numChecks = 0;

  always #2.5 sysClk = ~sysClk;

  // small data block of 16 words so range errors are cheap to reach
  fmv_flash_cmd_seq #(.DF_SIZE(17'h00020)) uut (
    .sys_clk(sysClk), .rst_n(rstN), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdata(regRdata), .specialMode(specialMode),
    .dflashProtected(dflashProtected), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .memEccErr(memEccErr),
    .memEccUncorr(memEccUncorr), .pflashMargin(pflashMargin), .dflashMargin(dflashMargin),
    .cmdIrq(cmdIrq));

  // array answers one cycle late; idle read data toggles so stale values never match
  always @(posedge sysClk) begin
    memAck <= memReq && !memAck;
    memEccErr <= injUnc && memReq && !memAck;
    memEccUncorr <= injUnc && memReq && !memAck;
    memRdata <= (memReq && !memAck) ? flashMem[memAddr[4:1]] : ~memRdata;
    if (memAck && memWrite) flashMem[memAddr[4:1]] <= memWdata;
  end

  task automatic stopTest();
    if (nFail == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stopTest

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sysClk);
    regWrStb <= 1'b1; regAddr <= a; regWdata <= d;
    @(posedge sysClk);
    regWrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input string what, input logic [15:0] exp);
    @(posedge sysClk);
    regRdStb <= 1'b1; regAddr <= a;
    @(posedge sysClk);
    regRdStb <= 1'b0;
    #1 check(what, exp, regRdata);
  endtask : rd

  task automatic run(input logic [15:0] w0, w1, w2, input logic [2:0] idx, input logic [15:0] expSt);
    for (int i = 0; i < 3; i++) begin
      wr(fmv_pkg::REG_INDEX, 16'(i));
      wr(fmv_pkg::REG_PARAM, (i == 0) ? w0 : (i == 1) ? w1 : w2);
    end
    wr(fmv_pkg::REG_INDEX, {13'h0000, idx});
    wr(ST, 16'h0030);
    wr(ST, 16'h0080);
    for (int n = 0; n < 60; n++) begin
      @(posedge sysClk);
      regRdStb <= 1'b1; regAddr <= ST;
      @(posedge sysClk);
      regRdStb <= 1'b0;
      #1 if (regRdata[7] === 1'b1) break;
      if (n == 59) begin nFail++; stopTest(); end
    end
    check("status", expSt, regRdata);
  endtask : run

  task automatic tReset();
    rd(ST, "status", 16'h0080);
    rd(fmv_pkg::REG_CONFIG, "config", 16'h0000);
    rd(MG, "margin", 16'h0000);
    rd(4'hf, "unmapped", 16'h0000);
  endtask : tReset

  task automatic tUser();
    for (int s = 0; s < 3; s++) begin
      run({UM, 8'h7f}, 16'(s), 16'h0, 3'h1, 16'h0080);
      run({UM, 8'h10}, 16'(2 - s), 16'h0, 3'h1, 16'h0080);
      rd(MG, "margin", {9'h000, 3'(2 - s), 1'b0, 3'(s)});
      check("pmargin", 16'(s), {13'h0000, pflashMargin});
      check("dmargin", 16'(2 - s), {13'h0000, dflashMargin});
    end
    run({UM, 8'h7f}, 16'h0003, 16'h0, 3'h1, 16'h00a0);
    run({UM, 8'h7f}, 16'h0001, 16'h0, 3'h2, 16'h00a0);
    run({UM, 8'h05}, 16'h0001, 16'h0, 3'h1, 16'h00a0);
    rd(MG, "margin", 16'h0002);
  endtask : tUser

  task automatic tField();
    run({FM, 8'h10}, 16'h0003, 16'h0, 3'h1, 16'h00a0);
    specialMode <= 1'b1;
    run({FM, 8'h10}, 16'h0003, 16'h0, 3'h1, 16'h0080);
    run({FM, 8'h7f}, 16'h0004, 16'h0, 3'h1, 16'h0080);
    run({FM, 8'h7f}, 16'h0005, 16'h0, 3'h1, 16'h00a0);
    rd(MG, "margin", 16'h0034);
    check("pmargin", 16'h0004, {13'h0000, pflashMargin});
    check("dmargin", 16'h0003, {13'h0000, dflashMargin});
    // back to normal reads once factory checks are over
    run({FM, 8'h10}, 16'h0000, 16'h0, 3'h1, 16'h0080);
    run({FM, 8'h7f}, 16'h0000, 16'h0, 3'h1, 16'h0080);
    specialMode <= 1'b0;
  endtask : tField

  task automatic tVerify();
    run(EV, 16'h0000, 16'h0002, 3'h2, 16'h0080);
    run(EV, 16'h001c, 16'h0002, 3'h2, 16'h0080);
    run(EV, 16'h001c, 16'h0003, 3'h2, 16'h00a0);
    run(EV, 16'h0000, 16'h0002, 3'h1, 16'h00a0);
    run({EV[15:8], 8'h7f}, 16'h0000, 16'h0002, 3'h2, 16'h00a0);
    run(EV, 16'h0001, 16'h0001, 3'h2, 16'h00a0);
    flashMem[3] = 16'h00ff;
    dflashProtected <= 1'b1;
    run(EV, 16'h0000, 16'h0004, 3'h2, 16'h0082);
    injUnc = 1'b1;
    run(EV, 16'h0000, 16'h0001, 3'h2, 16'h0083);
    injUnc = 1'b0;
    dflashProtected <= 1'b0;
    flashMem[3] = 16'hffff;
  endtask : tVerify

  task automatic tProgram();
    run(PG, 16'h0004, 16'h1234, 3'h2, 16'h0080);
    check("cell", 16'h1234, flashMem[2]);
    // four words: indices 3..5 survive the three words that run rewrites
    for (int i = 3; i < 6; i++) begin
      wr(fmv_pkg::REG_INDEX, 16'(i));
      wr(fmv_pkg::REG_PARAM, 16'(i * 16'h1111));
    end
    run(PG, 16'h0008, 16'h1111, 3'h5, 16'h0080);
    check("cell", 16'h1111, flashMem[4]);
    check("cell", 16'h3333, flashMem[5]);
    check("cell", 16'h5555, flashMem[7]);
    run(PG, 16'h0006, 16'h1234, 3'h1, 16'h00a0);
    run(PG, 16'h0006, 16'h1234, 3'h6, 16'h00a0);
    dflashProtected <= 1'b1;
    run(PG, 16'h0006, 16'h5678, 3'h2, 16'h0090);
    dflashProtected <= 1'b0;
    check("cell", 16'hffff, flashMem[3]);
  endtask : tProgram

  task automatic tIrq();
    wr(fmv_pkg::REG_CONFIG, 16'h0080);
    #1 check("irq", 16'h0001, {15'h0000, cmdIrq});
    run(16'hff00, 16'h0000, 16'h0000, 3'h0, 16'h00a0);
    check("irq", 16'h0001, {15'h0000, cmdIrq});
    wr(fmv_pkg::REG_CONFIG, 16'h0000);
    #1 check("irq", 16'h0000, {15'h0000, cmdIrq});
  endtask : tIrq

  initial begin
    foreach (flashMem[i]) flashMem[i] = 16'hffff;
    repeat (3) @(posedge sysClk);
    rstN <= 1'b1;
    tReset();
    tUser();
    tField();
    tVerify();
    tProgram();
    tIrq();
    stopTest();
  end
endmodule : fmv_flash_cmd_seq_tb

// *** fmv_pkg.sv ***
// constants, register map and state encoding for the flash margin and verify sequencer
// Summary of operation
// - user margin command 0x0D, block at word zero
// - valid user margin applied, then completion
// - user margin accepts settings 0 to 2
// - margin commands need index 001 at launch
// - command not allowed in mode: access error
// - margin commands: bad block select, access error
// - bad margin setting gives access error
// - field margin 0x0E, special modes only
// - field margin also accepts settings 3, 4
// - valid field margin applied, then completion
// - erase verify 0x10: block, address, count
// - erase verify checks each word erased
// - erase verify needs index 010 at launch
// - erase verify: invalid global address, error
// - erase verify: odd start address, error
// - erase verify: range past block end, error
// - verify errors set flags, never protection
// - program one to four words, then confirm
// - program index outside 010..101 is error
// - interrupt when complete and enable set
package fmv_pkg;
  // register offsets
  localparam logic [3:0]  REG_CONFIG   = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_INDEX    = 4'h2;
  localparam logic [3:0]  REG_PARAM    = 4'h3;
  localparam logic [3:0]  REG_MARGIN   = 4'h4;
  // field positions
  localparam int          CFG_IRQ_EN   = 7;
  localparam int          ST_COMPLETE  = 7;
  localparam int          ST_ACCESS    = 5;
  localparam int          ST_PROTECT   = 4;
  localparam int          ST_VERIFY    = 1;
  localparam int          ST_UNCORR    = 0;
  // reset values
  localparam logic [7:0]  CONFIG_RST   = 8'h00;
  localparam logic [2:0]  INDEX_RST    = 3'h0;
  localparam logic [2:0]  MARGIN_RST   = 3'h0;
  // command codes
  localparam logic [7:0]  CMD_USER_MRG = 8'h0d;
  localparam logic [7:0]  CMD_FLD_MRG  = 8'h0e;
  localparam logic [7:0]  CMD_EV_SECT  = 8'h10;
  localparam logic [7:0]  CMD_PROG_DF  = 8'h11;
  // parameter word indices
  localparam logic [2:0]  IDX_ADDR     = 3'h1;
  localparam logic [2:0]  IDX_COUNT    = 3'h2;
  localparam logic [2:0]  IDX_PROG_MIN = 3'h2;
  localparam logic [2:0]  IDX_PROG_MAX = 3'h5;
  // margin settings
  localparam logic [15:0] MRG_USER_MAX = 16'h0002;
  localparam logic [15:0] MRG_FLD_MAX  = 16'h0004;
  // block selects and data flash size
  localparam logic [6:0]  BLK_PFLASH   = 7'h7f;
  localparam logic [6:0]  BLK_DFLASH   = 7'h10;
  localparam logic [16:0] DF_BYTES     = 17'h02000;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [15:0] WORD_STEP    = 16'h0002;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'h0,
    SQ_CHECK = 3'h1,
    SQ_EV_RD = 3'h2,
    SQ_PG_WR = 3'h3,
    SQ_PG_RD = 3'h4,
    SQ_DONE  = 3'h5
  } fmv_state_t;
endpackage : fmv_pkg
